// ### bscp_pkg.sv
// package: register map, field positions and reset values for the strobe and chip-select ports
package bscp_pkg;
   // ---------------------------------------------------------------
   // register byte offsets (index times four)
   // ---------------------------------------------------------------
   localparam logic [7:0] STROBE_LATCH_IDX = 8'h07;
   localparam logic [7:0] STROBE_DIR_IDX = 8'h0A;
   localparam logic [7:0] STROBE_FUNC_IDX = 8'h0B;
   localparam logic [7:0] CS_LATCH_IDX = 8'h0C;
   localparam logic [7:0] CS_DIR_IDX = 8'h0E;
   localparam logic [7:0] CS_FUNC_IDX = 8'h0F;
   localparam logic [7:0] BUS_CTRL_IDX = 8'h10;
   localparam logic [9:0] STROBE_LATCH_ADDR = {STROBE_LATCH_IDX, 2'b00};
   localparam logic [9:0] STROBE_DIR_ADDR = {STROBE_DIR_IDX, 2'b00};
   localparam logic [9:0] STROBE_FUNC_ADDR = {STROBE_FUNC_IDX, 2'b00};
   localparam logic [9:0] CS_LATCH_ADDR = {CS_LATCH_IDX, 2'b00};
   localparam logic [9:0] CS_DIR_ADDR = {CS_DIR_IDX, 2'b00};
   localparam logic [9:0] CS_FUNC_ADDR = {CS_FUNC_IDX, 2'b00};
   localparam logic [9:0] BUS_CTRL_ADDR = {BUS_CTRL_IDX, 2'b00};
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int PIN_RD = 0;
   localparam int PIN_WR = 1;
   localparam int PIN_HWR = 2;
   localparam int BUS_EXT_BIT = 0;
   localparam logic [2:0] LATCH_RESET = 3'h7;
   localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage : bscp_pkg

// ### bscp_pin_mux.sv
// module: per-pin output mux with direction, function and pull-up select
`timescale 1ns/1ps
`default_nettype none
module bscp_pin_mux
(
   input wire logic latch_in,
   input wire logic dir_in,
   input wire logic func_in,
   input wire logic alt_in,
   output logic drive_out,
   output logic oe_out,
   output logic pullup_out
);
   // ---------------------------------------------------------------
   // output selection
   // ---------------------------------------------------------------
   // alternate function replaces the latch whenever the function bit is set, whatever the direction
   assign drive_out = func_in ? alt_in : latch_in;
   assign oe_out = dir_in;
   // input mode: latch bit steers pull-up
   assign pullup_out = ~dir_in & latch_in;
endmodule // bscp_pin_mux
`default_nettype wire

// ### bscp_top.sv
// module: strobe port and chip-select port registers, pin logic and apb slave
//
// Contract
// - chip-select port: three latch bits, three pins
// - per-pin direction and function bits; strobe pins 0 and 1 have no direction bit
// - reset sets chip-select latch to ones
// - reset clears direction/function; inputs with pull-up; strobe pins 0 and 1 stay outputs
// - chip-select pins carry active-low selects
// - third strobe pin drives upper-byte strobe
// - read strobe external only when latch one
// - input latch bit switches pull-up
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bscp_top
#(
   parameter int NPINS = 3
)
(
   input wire logic REF_CLK_IN,
   input wire logic RST_N_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   output logic [31:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   input wire logic RD_REQ_N_IN,
   input wire logic WR_REQ_N_IN,
   input wire logic HWR_REQ_N_IN,
   input wire logic EXT_ACCESS_IN,
   input wire logic [NPINS-1:0] CS_REQ_N_IN,
   input wire logic [NPINS-1:0] STROBE_PIN_IN,
   output logic [NPINS-1:0] STROBE_PIN_OUT,
   output logic [NPINS-1:0] STROBE_PIN_OE_OUT,
   output logic [NPINS-1:0] STROBE_PULLUP_OUT,
   input wire logic [NPINS-1:0] CS_PIN_IN,
   output logic [NPINS-1:0] CS_PIN_OUT,
   output logic [NPINS-1:0] CS_PIN_OE_OUT,
   output logic [NPINS-1:0] CS_PULLUP_OUT
);
   logic [NPINS-1:0] st_latch_reg, st_latch_next;
   logic [NPINS-1:0] st_dir_reg, st_dir_next;
   logic [NPINS-1:0] st_func_reg, st_func_next;
   logic [NPINS-1:0] cs_latch_reg, cs_latch_next;
   logic [NPINS-1:0] cs_dir_reg, cs_dir_next;
   logic [NPINS-1:0] cs_func_reg, cs_func_next;
   logic [NPINS-1:0] st_sync1_reg, st_sync2_reg, cs_sync1_reg, cs_sync2_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic err_reg, err_next;
   logic wr_en, rd_en;
   logic rd_strobe_n;
   logic [NPINS-1:0] st_alt, st_dir_eff, st_drive, st_oe, st_pu;
   logic [NPINS-1:0] cs_drive, cs_oe, cs_pu;
   // ---------------------------------------------------------------
   // apb access decode
   // ---------------------------------------------------------------
   // zero wait states: every access completes in its access phase
   assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
   assign rd_en = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   assign PREADY_OUT = 1'b1;
   assign PRDATA_OUT = rdata_reg;
   assign PSLVERR_OUT = err_reg & PSEL_IN & PENABLE_IN;

   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a[11:10] == 2'h0) && (a[9:0] == bscp_pkg::STROBE_LATCH_ADDR
         || a[9:0] == bscp_pkg::STROBE_DIR_ADDR || a[9:0] == bscp_pkg::STROBE_FUNC_ADDR
         || a[9:0] == bscp_pkg::CS_LATCH_ADDR || a[9:0] == bscp_pkg::CS_DIR_ADDR
         || a[9:0] == bscp_pkg::CS_FUNC_ADDR);
   endfunction

   // ---------------------------------------------------------------
   // register next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_latch_next = st_latch_reg;
      st_dir_next = st_dir_reg;
      st_func_next = st_func_reg;
      cs_latch_next = cs_latch_reg;
      cs_dir_next = cs_dir_reg;
      cs_func_next = cs_func_reg;
      err_next = err_reg;
      if (PSEL_IN && !PENABLE_IN)
      begin
         err_next = ~addr_known(PADDR_IN);
      end
      if (wr_en && addr_known(PADDR_IN))
      begin
         if (PADDR_IN[9:0] == bscp_pkg::STROBE_LATCH_ADDR)
         begin
            st_latch_next = PWDATA_IN[NPINS-1:0];
         end
         else if (PADDR_IN[9:0] == bscp_pkg::STROBE_DIR_ADDR)
         begin
            // only the third strobe pin has a direction bit
            st_dir_next = {PWDATA_IN[bscp_pkg::PIN_HWR], 2'b00};
         end
         else if (PADDR_IN[9:0] == bscp_pkg::STROBE_FUNC_ADDR)
         begin
            st_func_next = PWDATA_IN[NPINS-1:0];
         end
         else if (PADDR_IN[9:0] == bscp_pkg::CS_LATCH_ADDR)
         begin
            cs_latch_next = PWDATA_IN[NPINS-1:0];
         end
         else if (PADDR_IN[9:0] == bscp_pkg::CS_DIR_ADDR)
         begin
            cs_dir_next = PWDATA_IN[NPINS-1:0];
         end
         else if (PADDR_IN[9:0] == bscp_pkg::CS_FUNC_ADDR)
         begin
            cs_func_next = PWDATA_IN[NPINS-1:0];
         end
      end
   end

   // read data: latches read pin state; direction/function are write-only
   always_comb
   begin
      rdata_next = rdata_reg;
      if (rd_en)
      begin
         rdata_next = 32'h0000_0000;
         if (PADDR_IN[11:0] == {2'b00, bscp_pkg::STROBE_LATCH_ADDR})
         begin
            rdata_next[NPINS-1:0] = st_sync2_reg;
         end
         else if (PADDR_IN[11:0] == {2'b00, bscp_pkg::CS_LATCH_ADDR})
         begin
            rdata_next[NPINS-1:0] = cs_sync2_reg;
         end
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         st_latch_reg <= bscp_pkg::LATCH_RESET;
         st_dir_reg <= bscp_pkg::CTRL_RESET;
         st_func_reg <= bscp_pkg::CTRL_RESET;
         cs_latch_reg <= bscp_pkg::LATCH_RESET;
         cs_dir_reg <= bscp_pkg::CTRL_RESET;
         cs_func_reg <= bscp_pkg::CTRL_RESET;
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
         st_sync1_reg <= 3'h0;
         st_sync2_reg <= 3'h0;
         cs_sync1_reg <= 3'h0;
         cs_sync2_reg <= 3'h0;
      end
      else
      begin
         st_latch_reg <= st_latch_next;
         st_dir_reg <= st_dir_next;
         st_func_reg <= st_func_next;
         cs_latch_reg <= cs_latch_next;
         cs_dir_reg <= cs_dir_next;
         cs_func_reg <= cs_func_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
         st_sync1_reg <= STROBE_PIN_IN;
         st_sync2_reg <= st_sync1_reg;
         cs_sync1_reg <= CS_PIN_IN;
         cs_sync2_reg <= cs_sync1_reg;
      end
   end

   // ---------------------------------------------------------------
   // strobe routing
   // ---------------------------------------------------------------
   // latch one limits read strobe to external accesses
   assign rd_strobe_n = RD_REQ_N_IN | (st_latch_reg[bscp_pkg::PIN_RD] & ~EXT_ACCESS_IN);
   // function bits route read and write strobes
   assign st_alt = {HWR_REQ_N_IN, WR_REQ_N_IN, rd_strobe_n};
   // first two strobe pins are output-only
   assign st_dir_eff = {st_dir_reg[bscp_pkg::PIN_HWR], 2'b11};

   genvar g;
   generate
      for (g = 0; g < NPINS; g++)
      begin : g_pin
         // upper-byte strobe on third strobe pin
         bscp_pin_mux u_st
         (
            .latch_in(st_latch_reg[g]),
            .dir_in(st_dir_eff[g]),
            .func_in(st_func_reg[g]),
            .alt_in(st_alt[g]),
            .drive_out(st_drive[g]),
            .oe_out(st_oe[g]),
            .pullup_out(st_pu[g])
         );
         // latch steers pull-up in input mode
         bscp_pin_mux u_cs
         (
            .latch_in(cs_latch_reg[g]),
            .dir_in(cs_dir_reg[g]),
            .func_in(cs_func_reg[g]),
            .alt_in(CS_REQ_N_IN[g]),
            .drive_out(cs_drive[g]),
            .oe_out(cs_oe[g]),
            .pullup_out(cs_pu[g])
         );
      end
   endgenerate

   assign STROBE_PIN_OUT = st_drive;
   assign STROBE_PIN_OE_OUT = st_oe;
   assign STROBE_PULLUP_OUT = st_pu;
   assign CS_PIN_OUT = cs_drive;
   assign CS_PIN_OE_OUT = cs_oe;
   assign CS_PULLUP_OUT = cs_pu;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // ones after reset
   cs_latch_reset_a: assert property (@(posedge REF_CLK_IN)
      $rose(RST_N_IN) |-> cs_latch_reg == 3'h7)
      else $error("latch not ones after reset");
   cs_pullup_reset_a: assert property (@(posedge REF_CLK_IN)
      $rose(RST_N_IN) |-> CS_PULLUP_OUT == 3'h7 && CS_PIN_OE_OUT == 3'h0)
      else $error("pins not pulled-up inputs after reset");
   cs_dir_write_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      wr_en && PADDR_IN == {2'b00, bscp_pkg::CS_DIR_ADDR} |=> CS_PIN_OE_OUT == $past(PWDATA_IN[2:0]))
      else $error("direction write lost");
   cs_select_route_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      cs_func_reg[0] && cs_dir_reg[0] |-> CS_PIN_OUT[0] == CS_REQ_N_IN[0])
      else $error("chip select not routed");
   cs_pullup_ctl_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      !cs_dir_reg[1] |-> CS_PULLUP_OUT[1] == cs_latch_reg[1])
      else $error("pull-up not from latch");
   hwr_route_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      st_func_reg[2] && st_dir_reg[2] |-> STROBE_PIN_OUT[2] == HWR_REQ_N_IN && STROBE_PIN_OE_OUT[2])
      else $error("upper-byte strobe not routed");
   rd_internal_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      st_func_reg[0] && st_latch_reg[0] && !EXT_ACCESS_IN |-> STROBE_PIN_OUT[0])
      else $error("read strobe on internal access");
   wr_port_mode_a: assert property (@(posedge REF_CLK_IN) disable iff (!RST_N_IN)
      !st_func_reg[1] |-> STROBE_PIN_OUT[1] == st_latch_reg[1])
      else $error("write pin not latch in port mode");
   cs_drive_c: cover property (@(posedge REF_CLK_IN) cs_func_reg == 3'h7 && cs_dir_reg == 3'h7);
   hwr_drive_c: cover property (@(posedge REF_CLK_IN) st_func_reg[2] && st_dir_reg[2] && !HWR_REQ_N_IN);
   rd_internal_c: cover property (@(posedge REF_CLK_IN) st_func_reg[0] && !st_latch_reg[0] && !STROBE_PIN_OUT[0]);
endmodule // bscp_top
`default_nettype wire

// ### bscp_far_model.sv
// far-side model: external devices, pull-ups and floating pin lines
`timescale 1ns/1ps
`default_nettype none
module bscp_far_model
(
   input wire logic clk_in,
   input wire logic [2:0] oe_in,
   input wire logic [2:0] drv_in,
   input wire logic [2:0] pu_in,
   output logic [2:0] lvl_out
);
   logic [2:0] float_reg = 3'h5;
   // undriven lines without pull-up wander every cycle
   always @(posedge clk_in) float_reg <= ~float_reg;
   // wire level from every party on the pin
   assign lvl_out = (oe_in & drv_in) | (~oe_in & (pu_in | float_reg));
endmodule // bscp_far_model
`default_nettype wire

// ### bscp_top_tb_top.sv
// testbench: apb stimulus, pin model and comparisons for the port block
`timescale 1ns/1ps
`default_nettype none
module bscp_top_tb_top;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic rd_n = 1'b1, wr_n = 1'b1, hwr_n = 1'b1, ext = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h7B665605;
   logic [2:0] cs_req_n = 3'h7, sp_in, sp_out, sp_oe, sp_pu, cp_in, cp_out, cp_oe, cp_pu;
   logic [2:0] m_cl = 3'h7, m_cd = 3'h0, m_cf = 3'h0, m_sl = 3'h7, m_sd = 3'h0, m_sf = 3'h0;
   int num_errors = 0, n_tests = 0, cycles = 0;
   // clock generation
   initial forever #2.5 clk = ~clk;
   bscp_top i_dut (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .RD_REQ_N_IN(rd_n), .WR_REQ_N_IN(wr_n), .HWR_REQ_N_IN(hwr_n),
      .EXT_ACCESS_IN(ext), .CS_REQ_N_IN(cs_req_n), .STROBE_PIN_IN(sp_in), .STROBE_PIN_OUT(sp_out),
      .STROBE_PIN_OE_OUT(sp_oe), .STROBE_PULLUP_OUT(sp_pu), .CS_PIN_IN(cp_in), .CS_PIN_OUT(cp_out),
      .CS_PIN_OE_OUT(cp_oe), .CS_PULLUP_OUT(cp_pu));
   bscp_far_model i_far_st (.clk_in(clk), .oe_in(sp_oe), .drv_in(sp_out), .pu_in(sp_pu), .lvl_out(sp_in));
   bscp_far_model i_far_cs (.clk_in(clk), .oe_in(cp_oe), .drv_in(cp_out), .pu_in(cp_pu), .lvl_out(cp_in));
   function automatic logic [31:0] next_rand();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // apb transfer: setup, then access until pready at an edge
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, a};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // the first edge with pready high ends this wait; the hang guard catches a stuck pready
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, output logic [2:0] f);
      logic [31:0] d;
      d = next_rand();
      apb(1'b1, a, d);
      f = d[2:0];
   endtask
   task automatic rchk(input string nm, input logic [9:0] a, input logic [2:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, {29'h0, exp}, rd);
      chk("pslverr", 32'h0, {31'h0, err});
   endtask
   // strobe pin drive expected from the model registers
   function automatic logic [2:0] st_exp();
      st_exp[0] = m_sf[0] ? ~(~rd_n & (~m_sl[0] | ext)) : m_sl[0];
      st_exp[1] = m_sf[1] ? wr_n : m_sl[1];
      st_exp[2] = m_sf[2] ? hwr_n : m_sl[2];
   endfunction
   // latch reads return settled pin levels; floating unpulled lines masked
   task automatic pinrd();
      logic [2:0] cm, sm;
      cm = m_cd | m_cl;
      sm = {m_sd[2] | m_sl[2], 2'b11};
      apb(1'b0, bscp_pkg::CS_LATCH_ADDR, 32'h0);
      chk("cs_pins", {29'h0, ((m_cd & ((m_cf & cs_req_n) | (~m_cf & m_cl))) | (~m_cd & m_cl)) & cm},
         rd & {29'h0, cm});
      apb(1'b0, bscp_pkg::STROBE_LATCH_ADDR, 32'h0);
      chk("st_pins", {29'h0, ((st_exp() & {m_sd[2], 2'b11}) | {~m_sd[2] & m_sl[2], 2'b00}) & sm},
         rd & {29'h0, sm});
   endtask
   // pin outputs against the behavioural model
   task automatic pins();
      logic [2:0] so, som;
      so = st_exp();
      som = {m_sd[2], 2'b11};
      chk("cs_oe", m_cd, cp_oe);
      chk("cs_out", ((m_cf & cs_req_n) | (~m_cf & m_cl)) & m_cd, cp_out & m_cd);
      chk("cs_pullup", ~m_cd & m_cl, cp_pu);
      chk("st_oe", som, sp_oe);
      chk("st_out", so & som, sp_out & som);
      chk("st_pullup", {~m_sd[2] & m_sl[2], 2'b00}, sp_pu);
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 8000)
      begin
         num_errors++;
         stop_test();
      end
   end
   // main sequence
   initial
   begin
      logic [31:0] r;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      pins();
      rchk("cs_latch", bscp_pkg::CS_LATCH_ADDR, 3'h7);
      rchk("cs_dir", bscp_pkg::CS_DIR_ADDR, 3'h0);
      rchk("cs_func", bscp_pkg::CS_FUNC_ADDR, 3'h0);
      apb(1'b1, bscp_pkg::BUS_CTRL_ADDR, 32'hFFFFFFFF);
      chk("unmapped_werr", 32'h1, {31'h0, err});
      apb(1'b0, bscp_pkg::BUS_CTRL_ADDR, 32'h0);
      chk("unmapped_data", 32'h0, rd);
      chk("unmapped_err", 32'h1, {31'h0, err});
      pins();
      $display("test reset done");
      for (int i = 0; i < 60; i++)
      begin
         wr(bscp_pkg::CS_LATCH_ADDR, m_cl);
         wr(bscp_pkg::STROBE_LATCH_ADDR, m_sl);
         wr(bscp_pkg::CS_FUNC_ADDR, m_cf);
         wr(bscp_pkg::CS_DIR_ADDR, m_cd);
         wr(bscp_pkg::STROBE_FUNC_ADDR, m_sf);
         wr(bscp_pkg::STROBE_DIR_ADDR, m_sd);
         // the write-only strobe function register reads as zero, never modified in place
         rchk("st_func", bscp_pkg::STROBE_FUNC_ADDR, 3'h0);
         pinrd();
         for (int j = 0; j < 4; j++)
         begin
            @(posedge clk);
            r = next_rand();
            {rd_n, wr_n, hwr_n, ext, cs_req_n} <= r[6:0];
            @(posedge clk);
            pins();
         end
      end
      $display("test random done");
      // mid-run reset from a random configuration
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      {m_cl, m_cd, m_cf, m_sl, m_sd, m_sf} = {3'h7, 3'h0, 3'h0, 3'h7, 3'h0, 3'h0};
      @(posedge clk);
      pins();
      pinrd();
      rchk("cs_dir_rst", bscp_pkg::CS_DIR_ADDR, 3'h0);
      $display("test second reset done");
      stop_test();
   end
endmodule // bscp_top_tb_top
`default_nettype wire
